// File: hdl/fkc_consts.svh
// Constants for the front-panel key controller
// Overview of operation
// - State word bit n belongs to key n
// - Latching output holds until reset command or next press
// - Momentary output follows key held down
// - Momentary output stretched to minimum pulse
// - Disabled key gives no output at all
// - Locked key ignores all later presses
// - Locked latched-high output stays high until a restore
// - Locked momentary key output forced low
// - Only one key press handled at once
// - Press recognised after 200 ms qualification
// - Key states saved and restored over supply loss
// - Each key drives own ordinal signal, logs event
// - Each key drives configured tri-colour indicator
// - Mode bit: 0 momentary, 1 latching
// - Access code: 0 disabled, 1 unlocked, 2 locked
// - Each latching press inverts the output
`ifndef FKC_CONSTS_SVH
`define FKC_CONSTS_SVH

`define FKC_NUM_KEYS        3
`define FKC_QUAL_TIME_MS    200
`define FKC_CLK_HZ          125000000
`define FKC_QUAL_CYCLES     ((`FKC_CLK_HZ / 1000) * `FKC_QUAL_TIME_MS)
`define FKC_MIN_PULSE_W     24
`define FKC_FIRST_ORDINAL   712
`define FKC_ORDINAL_W       10
`define FKC_MODE_MOMENTARY  1'b0
`define FKC_MODE_LATCHING   1'b1
`define FKC_ACC_DISABLED    2'h0
`define FKC_ACC_UNLOCKED    2'h1
`define FKC_ACC_LOCKED      2'h2
`define FKC_LED_OFF         2'h0

`endif

// File: hdl/fkc_pkg.sv
// Types for the front-panel key controller
`include "fkc_consts.svh"
package fkc_pkg;
    typedef enum logic [1:0] {
        FKC_ACC_DIS_E = 2'h0,
        FKC_ACC_UNL_E = 2'h1,
        FKC_ACC_LCK_E = 2'h2
    } fkc_access_t;

    typedef struct packed {
        logic        key_behaviour_select;
        fkc_access_t key_access_setting;
        logic [1:0]  led_colour;
    } fkc_key_cfg_t;

    typedef struct packed {
        logic                         valid;
        logic [`FKC_ORDINAL_W-1:0]    ordinal;
    } fkc_event_t;

    typedef enum logic [2:0] {
        FKC_ST_IDLE = 3'b001,
        FKC_ST_QUAL = 3'b010,
        FKC_ST_HELD = 3'b100
    } fkc_state_t;
endpackage

// File: hdl/fkc_pulse_stretch.sv
// Minimum pulse stretcher for one momentary key output
`include "fkc_consts.svh"
module fkc_pulse_stretch
    import fkc_pkg::*;
#(
    parameter int W = `FKC_MIN_PULSE_W
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Control
    input  wire logic [W-1:0] min_cycles_i,
    input  wire logic         level_i,
    input  wire logic         kill_i,
    // Result
    output logic              level_o
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         level_q;
    logic         rise_q;
    logic         level_d;

    always_comb begin
        cnt_d   = cnt_q;
        level_d = 1'b0;
        if (kill_i) begin
            cnt_d = '0;
        end else if (level_i && !rise_q) begin
            cnt_d   = min_cycles_i;
            level_d = 1'b1;
        end else if (level_i) begin
            level_d = 1'b1;
            if (cnt_q != '0) cnt_d = cnt_q - W'(1);
        end else if (cnt_q != '0) begin
            // Short press still held out to full width
            cnt_d   = cnt_q - W'(1);
            level_d = (cnt_q != W'(1));
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q   <= '0;
            level_q <= 1'b0;
            rise_q  <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            level_q <= level_d;
            rise_q  <= level_i && !kill_i;
        end
    end

    assign level_o = level_q;
endmodule

// File: hdl/fkc_top.sv
// Front-panel key controller: qualify, arbitrate, latch or follow
`include "fkc_consts.svh"
module fkc_top
    import fkc_pkg::*;
#(
    parameter int N       = `FKC_NUM_KEYS,
    parameter int QUAL    = `FKC_QUAL_CYCLES,
    parameter int CNT_W   = 32,
    parameter int PULSE_W = `FKC_MIN_PULSE_W
) (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    // Operator keys, high while pressed
    input  wire logic [N-1:0]             key_pressed_i,
    // Configuration
    input  fkc_key_cfg_t [N-1:0]          key_cfg_i,
    input  wire logic [CNT_W-1:0]         qual_prescale_i,
    input  wire logic [PULSE_W-1:0]       min_pulse_cycles_i,
    input  wire logic [N-1:0]             latch_reset_i,
    // Non-volatile store
    input  wire logic                     nv_restore_i,
    input  wire logic [N-1:0]             nv_state_i,
    output logic                          nv_save_o,
    // Scheme logic side
    output logic [N-1:0]                  internal_signal_bus_o,
    output logic [N-1:0]                  key_state_word_o,
    output logic [N-1:0][1:0]             led_o,
    output fkc_event_t                    event_o
);
    localparam logic [CNT_W-1:0] QUAL_DEF = CNT_W'(QUAL);

    fkc_state_t                st_q, st_d;
    logic [CNT_W-1:0]          cnt_q, cnt_d;
    logic [$clog2(N+1)-1:0]    sel_q, sel_d;
    logic [N-1:0]              tog_q, tog_d;
    logic [N-1:0]              key_lvl;
    logic [N-1:0]              mom_lvl;
    logic [N-1:0]              mom_out;
    logic [N-1:0]              rise;
    logic                      hit;
    logic [CNT_W-1:0]          target;
    fkc_event_t                ev_d, ev_q;
    logic                      save_d, save_q;
    logic [N-1:0][1:0]         led_d, led_q;

    // Zero prescale falls back to the nominal qualification count
    assign target = (qual_prescale_i == '0) ? QUAL_DEF : qual_prescale_i;

    ////////////////////////////////////////////////////////////////////////
    // Press qualification and single-key arbitration

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        sel_d = sel_q;
        hit   = 1'b0;
        unique case (st_q)
            FKC_ST_IDLE: begin
                // Lowest key wins; others wait for the next idle
                for (int i = N - 1; i >= 0; i--) begin
                    if (key_pressed_i[i]) begin
                        sel_d = ($clog2(N+1))'(i);
                        st_d  = FKC_ST_QUAL;
                        cnt_d = CNT_W'(1);
                    end
                end
            end
            FKC_ST_QUAL: begin
                if (!key_pressed_i[sel_q]) begin
                    st_d  = FKC_ST_IDLE;
                    cnt_d = '0;
                end else if (cnt_q >= target) begin
                    st_d = FKC_ST_HELD;
                    hit  = 1'b1;
                end else begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
            end
            FKC_ST_HELD: begin
                if (!key_pressed_i[sel_q]) begin
                    st_d  = FKC_ST_IDLE;
                    cnt_d = '0;
                end
            end
            default: begin
                // Illegal one-hot code: fall back to idle rather than hang
                st_d  = FKC_ST_IDLE;
                cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q  <= FKC_ST_IDLE;
            cnt_q <= '0;
            sel_q <= '0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            sel_q <= sel_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-key output logic

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_key
            logic lat, dis, lck;
            assign lat = (key_cfg_i[g].key_behaviour_select == `FKC_MODE_LATCHING);
            assign dis = (key_cfg_i[g].key_access_setting == FKC_ACC_DIS_E);
            assign lck = (key_cfg_i[g].key_access_setting == FKC_ACC_LCK_E);
            assign rise[g] = hit && (sel_q == ($clog2(N+1))'(g));

            always_comb begin
                tog_d[g] = tog_q[g];
                if (nv_restore_i) begin
                    tog_d[g] = nv_state_i[g];
                end else if (rise[g] && lat && !dis && !lck) begin
                    tog_d[g] = ~tog_q[g];
                end else if (latch_reset_i[g] && !lck) begin
                    tog_d[g] = 1'b0;
                end
            end

            // Momentary level only from a qualified press, never when locked
            assign mom_lvl[g] = !lat && !dis && !lck && (st_q == FKC_ST_HELD)
                                && (sel_q == ($clog2(N+1))'(g));

            fkc_pulse_stretch #(
                .W(PULSE_W)
            ) u_stretch (
                .clk_i       (clk_i),
                .rst_n_i     (rst_n_i),
                .min_cycles_i(min_pulse_cycles_i),
                .level_i     (mom_lvl[g]),
                .kill_i      (lat || dis || lck),
                .level_o     (mom_out[g])
            );

            // Locked latched state simply keeps tog_q, so high stays high
            // Lock gates the stretcher too: its register lags a lock by a cycle
            assign key_lvl[g] = dis ? 1'b0 : (lat ? tog_q[g] : (mom_out[g] && !lck));

            always_comb begin
                led_d[g] = key_lvl[g] ? key_cfg_i[g].led_colour : `FKC_LED_OFF;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Event queue: rises landing together are reported one per cycle

    logic [N-1:0] prev_q, prev_d;
    logic [N-1:0] pend_q, pend_d;
    logic [N-1:0] key_rise;

    assign key_rise = key_lvl & ~prev_q;

    always_comb begin
        prev_d = key_lvl;
        ev_d   = '0;
        // Pending reports wait for a free cycle instead of being dropped
        pend_d = pend_q | key_rise;
        for (int i = 0; i < N; i++) begin
            if (pend_d[i] && !ev_d.valid) begin
                ev_d.valid   = 1'b1;
                ev_d.ordinal = `FKC_ORDINAL_W'(`FKC_FIRST_ORDINAL + i);
                // A second rise of the same key keeps its own report
                pend_d[i]    = pend_q[i] && key_rise[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_q <= '0;
            pend_q <= '0;
            ev_q   <= '0;
        end else begin
            prev_q <= prev_d;
            pend_q <= pend_d;
            ev_q   <= ev_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latched key state and save strobe

    always_comb begin
        // Restore writes back the stored image, so no save follows it
        save_d = (tog_d != tog_q) && !nv_restore_i;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tog_q  <= '0;
            save_q <= 1'b0;
        end else begin
            tog_q  <= tog_d;
            save_q <= save_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indicators and registered outputs

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            led_q <= '0;
        end else begin
            led_q <= led_d;
        end
    end

    assign internal_signal_bus_o = prev_q;
    assign key_state_word_o      = prev_q;
    assign led_o                 = led_q;
    assign event_o               = ev_q;
    assign nv_save_o             = save_q;
endmodule

// File: dv/fkc_checker.sv
// Port assertions for the key controller
module fkc_checker
    import fkc_pkg::*;
#(
    parameter int N = 3
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // Watched ports
    input  wire logic [N-1:0]      key_pressed_i,
    input  fkc_key_cfg_t [N-1:0]   key_cfg_i,
    input  wire logic              nv_restore_i,
    input  wire logic              nv_save_o,
    input  wire logic [N-1:0]      internal_signal_bus_o,
    input  wire logic [N-1:0]      key_state_word_o,
    input  wire logic [N-1:0][1:0] led_o,
    input  fkc_event_t             event_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////
    a_word_match: assert property (key_state_word_o == internal_signal_bus_o)
        else $error("state word differs from key outputs");
    a_dis_quiet: assert property ($past(key_cfg_i[2].key_access_setting) == FKC_ACC_DIS_E |->
        !internal_signal_bus_o[2] && led_o[2] == 2'h0) else $error("disabled key is active");
    a_led_follow: assert property ($stable(key_cfg_i[0].led_colour) |->
        led_o[0] == (internal_signal_bus_o[0] ? key_cfg_i[0].led_colour : 2'h0))
        else $error("indicator does not follow key output");
    a_lock_mom: assert property ($past(key_cfg_i[1].key_access_setting) == FKC_ACC_LCK_E &&
        !$past(key_cfg_i[1].key_behaviour_select) |-> !internal_signal_bus_o[1])
        else $error("locked momentary key is active");
    // Two cycles of lock so an in-flight toggle is not blamed
    a_lock_hold: assert property ($past(key_cfg_i[0].key_access_setting == FKC_ACC_LCK_E &&
        key_cfg_i[0].key_behaviour_select && !nv_restore_i, 2) &&
        $past(key_cfg_i[0].key_access_setting == FKC_ACC_LCK_E && key_cfg_i[0].key_behaviour_select)
        |-> $stable(internal_signal_bus_o[0])) else $error("locked key output changed");
    a_event_key: assert property (event_o.valid |-> event_o.ordinal >= 10'h2c8 &&
        event_o.ordinal <= 10'h2ca && internal_signal_bus_o[event_o.ordinal - 10'h2c8])
        else $error("event ordinal does not match an active key");
    a_save_pulse: assert property (nv_save_o |=> !nv_save_o)
        else $error("save request longer than one cycle");
    a_mom_release: assert property ((!key_pressed_i[1] && !key_cfg_i[1].key_behaviour_select)[*8]
        |-> ##2 !internal_signal_bus_o[1]) else $error("momentary output outlives release");
    cover property (event_o.valid);
    cover property (nv_restore_i);
    cover property ($fell(internal_signal_bus_o[1]));
    cover property (key_cfg_i[0].key_access_setting == FKC_ACC_LCK_E && key_pressed_i[0]);
endmodule

bind fkc_top fkc_checker #(.N(N)) u_fkc_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .key_pressed_i(key_pressed_i), .key_cfg_i(key_cfg_i), .nv_restore_i(nv_restore_i),
    .nv_save_o(nv_save_o), .internal_signal_bus_o(internal_signal_bus_o),
    .key_state_word_o(key_state_word_o), .led_o(led_o), .event_o(event_o));

// File: dv/fkc_operator.sv
// Operator model holding front-panel keys
module fkc_operator (
    // Clock
    input  wire logic clk_i,
    // Keys, high while held
    output logic [2:0] key_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial key_o = 3'h0;
    // Falling edge keeps presses clear of the sampling edge
    task automatic hold(input int k, input int n);
        @(negedge clk_i);
        key_o[k] = 1'b1;
        repeat (n) @(negedge clk_i);
        key_o[k] = 1'b0;
    endtask
endmodule

// File: dv/tb_function_key_controller.sv
// Testbench for the key controller
module tb_function_key_controller;
    import fkc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rest = 1'b0;
    logic save;
    logic [2:0] keys, lrst, nvs, bus, word;
    logic [2:0][1:0] led;
    fkc_key_cfg_t [2:0] cfg;
    fkc_event_t ev;
    logic [9:0] last_ord;
    int hi_cnt, sv_cnt, mismatches, total_checks;
    ////////////////////////////////////////
    always #4 clk = ~clk;
    fkc_operator ops (.clk_i(clk), .key_o(keys));
    // Short qualification keeps the run brief
    fkc_top #(.N(3)) dut (.clk_i(clk), .rst_n_i(rst_n), .key_pressed_i(keys), .key_cfg_i(cfg),
        .qual_prescale_i(32'h0000_000a), .min_pulse_cycles_i(24'h00_0005), .latch_reset_i(lrst),
        .nv_restore_i(rest), .nv_state_i(nvs), .nv_save_o(save), .internal_signal_bus_o(bus),
        .key_state_word_o(word), .led_o(led), .event_o(ev));
    always @(posedge clk) begin
        if (ev.valid) last_ord <= ev.ordinal;
        if (bus[1]) hi_cnt <= hi_cnt + 1;
        if (save) sv_cnt <= sv_cnt + 1;
    end
    task automatic chk_w(input logic [2:0] got, input logic [2:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input logic [9:0] got, input logic [9:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic set(input int k, input logic m, input fkc_access_t a);
        @(negedge clk);
        cfg[k].key_behaviour_select = m;
        cfg[k].key_access_setting = a;
    endtask
    task automatic pr(input int k, input int n);
        ops.hold(k, n);
        repeat (8) @(negedge clk);
    endtask
    task automatic pulse(ref logic [2:0] s, input logic [2:0] v);
        @(negedge clk);
        s = v;
        @(negedge clk);
        s = 3'h0;
        repeat (4) @(negedge clk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        finish_test();
    end
    ////////////////////////////////////////
    initial begin
        lrst = 3'h0;
        nvs = 3'h0;
        hi_cnt = 0;
        cfg = {1'b1, FKC_ACC_UNL_E, 2'h2, 1'b0, FKC_ACC_UNL_E, 2'h1, 1'b1, FKC_ACC_UNL_E, 2'h3};
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        chk_w(word, 3'h0);
        pr(0, 20);
        chk_w(word, 3'h1);
        chk_n(last_ord, 10'h2c8);
        chk_n(10'(led[0]), 10'h003);
        chk_n(10'(sv_cnt), 10'h001);
        pr(0, 20);
        chk_w(word, 3'h0);
        pr(0, 7);
        chk_w(word, 3'h0);
        pr(0, 20);
        // Key 2 arrives while key 0 qualifies and must be ignored
        fork
            ops.hold(0, 20);
            begin repeat (3) @(negedge clk); ops.hold(2, 20); end
        join
        repeat (8) @(negedge clk);
        chk_w(word, 3'h0);
        pr(2, 20);
        chk_w(word, 3'h4);
        chk_n(last_ord, 10'h2ca);
        pulse(lrst, 3'h4);
        chk_w(word, 3'h0);
        pr(0, 20);
        set(0, 1'b1, FKC_ACC_LCK_E);
        pr(0, 20);
        chk_w(word, 3'h1);
        pulse(lrst, 3'h1);
        chk_w(word, 3'h1);
        fork
            ops.hold(1, 20);
            begin repeat (16) @(negedge clk); chk_w(bus, 3'h3); end
        join
        repeat (10) @(negedge clk);
        chk_w(word, 3'h1);
        hi_cnt = 0;
        pr(1, 13);
        repeat (4) @(negedge clk);
        chk_n(10'(hi_cnt >= 5), 10'h001);
        set(2, 1'b1, FKC_ACC_DIS_E);
        pr(2, 20);
        chk_w(word, 3'h1);
        set(1, 1'b0, FKC_ACC_LCK_E);
        fork
            ops.hold(1, 20);
            begin repeat (16) @(negedge clk); chk_w(bus, 3'h1); end
        join
        set(0, 1'b1, FKC_ACC_UNL_E);
        set(2, 1'b1, FKC_ACC_UNL_E);
        // Clear then restore, so keys 0 and 2 rise in one cycle
        @(negedge clk);
        rest = 1'b1;
        @(negedge clk);
        nvs = 3'h5;
        @(negedge clk);
        rest = 1'b0;
        repeat (4) @(negedge clk);
        chk_w(word, 3'h5);
        chk_n(last_ord, 10'h2ca);
        finish_test();
    end
endmodule
